// *** rtl/audio_mon_defs.vh ***
// Purpose: shared constants of the audio input word monitor
// Assumes: included by bare name from the design files
// Notes: offsets are byte addresses on a 32-bit AXI4-Lite bus
`ifndef AUDIO_MON_DEFS_VH
`define AUDIO_MON_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_TX_LEN 8'h04
`define REG_RATE_REF 8'h08
`define REG_QUAL_THR 8'h0C
`define REG_FLAGS 8'h10
`define REG_SCALE 8'h14
`define REG_PEAK_A 8'h18
`define REG_PEAK_B 8'h1C
`define REG_BITS_A 8'h20
`define REG_BITS_B 8'h24

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTRL_LEN_LSB 0
`define CTRL_LAW_LSB 5
`define CTRL_DEEMPH_LSB 7
`define CTRL_SCALE_LSB 10
`define CTRL_PEAK_LSB 12
`define CTRL_VIEW_BIT 14
`define CTRL_TRIG_LSB 15

// ----------------------------------------
// encodings and limits
// ----------------------------------------
`define LEN_MIN 5'h08
`define LEN_MAX 5'h18
`define AUX_LIMIT 5'h14
`define LAW_LINEAR 2'h0
`define LAW_MU 2'h1
`define LAW_A 2'h2
`define DEEMPH_LAST 3'h4
`define SRC_TX 2'h0
`define SRC_MEAS 2'h1
`define SRC_STATUS 2'h2
`define SRC_USER 2'h3
`define PEAK_POS 2'h0
`define PEAK_NEG 2'h1
`define PEAK_ABS 2'h2
`define PEAK_HALF 2'h3
`define RATE_MIN 18'h07080
`define RATE_MAX 18'h34BC0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_LEN 5'h18
`define RST_RATE_REF 18'h0BB80
`define RST_QUAL_THR 8'h30

// ----------------------------------------
// timing
// ----------------------------------------
`define INTERVAL_MS 250
`define CLK_MHZ 250
`define INTERVAL_CYCLES (`INTERVAL_MS * `CLK_MHZ * 1000)

`endif

// *** rtl/chan_monitor.v ***
// Purpose: per-channel peak monitor and data bit view
// Assumes: i_tick pulses once per measurement interval
// Notes: results update only at the tick
`timescale 1ns/1ns
`default_nettype none
`include "audio_mon_defs.vh"

module chan_monitor #(
  parameter WIDTH = 24
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_valid,
  input wire [WIDTH-1:0] i_sample,
  input wire i_tick,
  input wire [1:0] i_mode,
  input wire i_view_act,
  output reg [WIDTH-1:0] o_peak,
  output reg [WIDTH-1:0] o_bits
);

  reg signed [WIDTH-1:0] hi;
  reg signed [WIDTH-1:0] lo;
  reg seen;
  reg [WIDTH-1:0] last;
  reg [WIDTH-1:0] toggles;
  wire signed [WIDTH:0] span;
  wire [WIDTH-1:0] mag_hi;
  wire [WIDTH-1:0] mag_lo;
  reg [WIDTH-1:0] next_peak;

  assign span = {hi[WIDTH-1], hi} - {lo[WIDTH-1], lo};
  assign mag_hi = hi[WIDTH-1] ? {WIDTH{1'b0}} : hi;
  // most negative code has no positive twin, so it saturates
  assign mag_lo = (lo == {1'b1, {(WIDTH-1){1'b0}}}) ? {1'b0, {(WIDTH-1){1'b1}}} :
                  (lo[WIDTH-1] ? {WIDTH{1'b0}} - lo : lo);

  always @* begin
    case (i_mode)
      `PEAK_POS: next_peak = hi;
      `PEAK_NEG: next_peak = lo;
      `PEAK_ABS: next_peak = (mag_hi > mag_lo) ? mag_hi : mag_lo;
      `PEAK_HALF: next_peak = span[WIDTH:1];
      default: next_peak = hi;
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hi <= {WIDTH{1'b0}};
      lo <= {WIDTH{1'b0}};
      seen <= 1'b0;
      last <= {WIDTH{1'b0}};
      toggles <= {WIDTH{1'b0}};
      o_peak <= {WIDTH{1'b0}};
      o_bits <= {WIDTH{1'b0}};
    end else begin
      if (i_tick) begin
        o_peak <= seen ? next_peak : {WIDTH{1'b0}};
        o_bits <= i_view_act ? toggles : last;
        seen <= i_valid;
        toggles <= i_valid ? (i_sample ^ last) : {WIDTH{1'b0}};
        if (i_valid) begin
          hi <= i_sample;
          lo <= i_sample;
        end
      end else if (i_valid) begin
        seen <= 1'b1;
        toggles <= toggles | (i_sample ^ last);
        if (!seen || $signed(i_sample) > hi)
          hi <= i_sample;
        if (!seen || $signed(i_sample) < lo)
          lo <= i_sample;
      end
      if (i_valid)
        last <= i_sample;
    end
  end

endmodule // chan_monitor
`default_nettype wire

// *** rtl/audio_input_word_monitor.v ***
// Purpose: receive word processing, peak and bit monitors, error flags
// Assumes: subframe decoder on i_clk feeds 32 time slots per subframe
// Notes: de-emphasis filter lies downstream, driven by o_deemph_sel
`timescale 1ns/1ns
`default_nettype none
`include "audio_mon_defs.vh"

module audio_input_word_monitor #(
  parameter INTERVAL_CYCLES = `INTERVAL_CYCLES,
  parameter RATE_W = 18
) (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  input wire i_sub_valid,
  input wire i_sub_chan,
  input wire [31:0] i_sub_bits,
  input wire [4:0] i_in_len,
  input wire i_coding_err,
  input wire i_pre_valid,
  input wire [7:0] i_pre_amp_long,
  input wire [7:0] i_pre_amp_short,
  input wire i_pll_locked,
  input wire [RATE_W-1:0] i_tx_rate,
  input wire [RATE_W-1:0] i_meas_rate,
  input wire [RATE_W-1:0] i_status_rate,
  output reg [23:0] o_sample,
  output reg o_sample_valid,
  output reg o_sample_chan,
  output wire [2:0] o_deemph_sel,
  output reg [RATE_W-1:0] o_scale_rate,
  output wire [4:0] o_tx_word_len,
  output wire [3:0] o_err_flags,
  output reg o_chan_a_validity_flag,
  output reg o_chan_b_validity_flag,
  output reg o_trigger
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [4:0] rx_len;
  reg [4:0] tx_len;
  reg [1:0] law;
  reg [2:0] deemph;
  reg [1:0] scale_sel;
  reg [1:0] peak_mode;
  reg view_act;
  reg [3:0] trig_mask;
  reg [RATE_W-1:0] rate_ref;
  reg [7:0] qual_thr;
  reg flag_qual;
  reg flag_lock;
  reg flag_coding;
  reg flag_parity;
  reg [3:0] flags_prev;
  reg lock_meta;
  reg lock_sync;
  reg [31:0] interval_cnt;
  reg tick;
  wire [23:0] peak [0:1];
  wire [23:0] bits [0:1];

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire;
  wire [31:0] ctrl_word;
  wire [31:0] wr_ctrl;
  wire [31:0] wr_tx;
  wire [31:0] wr_rate;
  wire [31:0] wr_thr;
  wire wr_known;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = din[k*8 +: 8];
    end
  endfunction

  assign o_awready = !aw_hold && !o_bvalid;
  assign o_wready = !w_hold && !o_bvalid;
  assign wr_fire = aw_hold && w_hold && !o_bvalid;
  assign ctrl_word = {13'h0000, trig_mask, view_act, peak_mode, scale_sel,
                      deemph, law, rx_len};
  assign wr_ctrl = merge(ctrl_word, w_data, w_strb);
  assign wr_tx = merge({27'h0000000, tx_len}, w_data, w_strb);
  assign wr_rate = merge({14'h0000, rate_ref}, w_data, w_strb);
  assign wr_thr = merge({24'h000000, qual_thr}, w_data, w_strb);
  assign wr_known = (aw_addr == `REG_CTRL) || (aw_addr == `REG_TX_LEN) ||
                    (aw_addr == `REG_RATE_REF) || (aw_addr == `REG_QUAL_THR);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_len <= `RST_LEN;
      tx_len <= `RST_LEN;
      law <= `LAW_LINEAR;
      deemph <= 3'h0;
      scale_sel <= `SRC_MEAS;
      peak_mode <= `PEAK_POS;
      view_act <= 1'b0;
      trig_mask <= 4'h0;
      rate_ref <= `RST_RATE_REF;
      qual_thr <= `RST_QUAL_THR;
    end else if (wr_fire) begin
      case (aw_addr)
        `REG_CTRL: begin
          if (wr_ctrl[`CTRL_LEN_LSB +: 5] >= `LEN_MIN &&
              wr_ctrl[`CTRL_LEN_LSB +: 5] <= `LEN_MAX)
            rx_len <= wr_ctrl[`CTRL_LEN_LSB +: 5];
          if (wr_ctrl[`CTRL_LAW_LSB +: 2] != 2'h3)
            law <= wr_ctrl[`CTRL_LAW_LSB +: 2];
          if (wr_ctrl[`CTRL_DEEMPH_LSB +: 3] <= `DEEMPH_LAST)
            deemph <= wr_ctrl[`CTRL_DEEMPH_LSB +: 3];
          scale_sel <= wr_ctrl[`CTRL_SCALE_LSB +: 2];
          peak_mode <= wr_ctrl[`CTRL_PEAK_LSB +: 2];
          view_act <= wr_ctrl[`CTRL_VIEW_BIT];
          trig_mask <= wr_ctrl[`CTRL_TRIG_LSB +: 4];
        end
        `REG_TX_LEN: begin
          if (wr_tx[4:0] >= `LEN_MIN && wr_tx[4:0] <= `LEN_MAX)
            tx_len <= wr_tx[4:0];
        end
        `REG_RATE_REF: begin
          if (wr_rate[31:RATE_W] == 0 && wr_rate[RATE_W-1:0] >= `RATE_MIN &&
              wr_rate[RATE_W-1:0] <= `RATE_MAX)
            rate_ref <= wr_rate[RATE_W-1:0];
        end
        `REG_QUAL_THR: qual_thr <= wr_thr[7:0];
        default: qual_thr <= qual_thr;
      endcase
    end
  end

  assign o_tx_word_len = tx_len;
  assign o_deemph_sel = deemph;

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  reg [31:0] next_rdata;
  reg next_rok;

  assign o_arready = !o_rvalid;

  always @* begin
    next_rok = 1'b1;
    case (i_araddr)
      `REG_CTRL: next_rdata = ctrl_word;
      `REG_TX_LEN: next_rdata = {27'h0000000, tx_len};
      `REG_RATE_REF: next_rdata = {14'h0000, rate_ref};
      `REG_QUAL_THR: next_rdata = {24'h000000, qual_thr};
      `REG_FLAGS: next_rdata = {26'h0000000, o_chan_b_validity_flag,
                                o_chan_a_validity_flag, o_err_flags};
      `REG_SCALE: next_rdata = {14'h0000, o_scale_rate};
      `REG_PEAK_A: next_rdata = {{8{peak[0][23]}}, peak[0]};
      `REG_PEAK_B: next_rdata = {{8{peak[1][23]}}, peak[1]};
      // bit 24 sits at bit 23
      `REG_BITS_A: next_rdata = {8'h00, bits[0]};
      `REG_BITS_B: next_rdata = {8'h00, bits[1]};
      default: begin
        next_rdata = 32'h00000000;
        next_rok = 1'b0;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= next_rdata;
      o_rresp <= next_rok ? 2'h0 : 2'h2;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // word processing
  // ----------------------------------------
  // companded code rides in the top byte of the audio slots
  function [15:0] mu_expand;
    input [7:0] code;
    reg [7:0] c;
    reg [15:0] mag;
    begin
      c = ~code;
      mag = (({8'h00, 1'b0, c[3:0], 3'h0} + 16'h0084) << c[6:4]) - 16'h0084;
      mu_expand = c[7] ? 16'h0000 - mag : mag;
    end
  endfunction

  function [15:0] a_expand;
    input [7:0] code;
    reg [7:0] c;
    reg [15:0] mag;
    begin
      c = code ^ 8'h55;
      mag = {8'h00, c[3:0], 4'h8};
      if (c[6:4] != 3'h0)
        mag = (mag + 16'h0100) << (c[6:4] - 3'h1);
      a_expand = c[7] ? mag : 16'h0000 - mag;
    end
  endfunction

  wire [23:0] raw_word;
  wire [23:0] len_mask;
  reg [23:0] next_word;

  assign raw_word = i_sub_bits[27:4];
  assign len_mask = ~((24'h000001 << (`LEN_MAX - rx_len)) - 24'h000001);

  always @* begin
    case (law)
      `LAW_MU: next_word = {mu_expand(raw_word[23:16]), 8'h00};
      `LAW_A: next_word = {a_expand(raw_word[23:16]), 8'h00};
      default: begin
        if (rx_len >= i_in_len && rx_len > `AUX_LIMIT)
          next_word = raw_word;
        else
          next_word = raw_word & len_mask;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample <= 24'h000000;
      o_sample_valid <= 1'b0;
      o_sample_chan <= 1'b0;
    end else begin
      o_sample_valid <= i_sub_valid;
      if (i_sub_valid) begin
        o_sample <= next_word;
        o_sample_chan <= i_sub_chan;
      end
    end
  end

  // ----------------------------------------
  // interval timer and monitors
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      interval_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      tick <= (interval_cnt == INTERVAL_CYCLES - 1);
      if (interval_cnt == INTERVAL_CYCLES - 1)
        interval_cnt <= 32'h00000000;
      else
        interval_cnt <= interval_cnt + 32'h00000001;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      chan_monitor #(
        .WIDTH(24)
      ) u_mon (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(o_sample_valid && (o_sample_chan == ch)),
        .i_sample(o_sample),
        .i_tick(tick),
        .i_mode(peak_mode),
        .i_view_act(view_act),
        .o_peak(peak[ch]),
        .o_bits(bits[ch])
      );
    end
  endgenerate

  // ----------------------------------------
  // frequency reference
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_scale_rate <= `RST_RATE_REF;
    end else begin
      case (scale_sel)
        `SRC_TX: o_scale_rate <= i_tx_rate;
        `SRC_MEAS: o_scale_rate <= i_meas_rate;
        `SRC_STATUS: o_scale_rate <= i_status_rate;
        default: o_scale_rate <= rate_ref;
      endcase
    end
  end

  // ----------------------------------------
  // error and validity flags
  // ----------------------------------------
  wire [15:0] long_scaled;
  wire [15:0] short_scaled;

  assign long_scaled = {4'h0, i_pre_amp_long, 4'h0};
  assign short_scaled = i_pre_amp_short * qual_thr;
  assign o_err_flags = {flag_parity, flag_coding, flag_lock, flag_qual};

  // lock comes straight from the loop pin, so it is synchronised
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= i_pll_locked;
      lock_sync <= lock_meta;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_qual <= 1'b0;
      flag_lock <= 1'b1;
      flag_coding <= 1'b0;
      flag_parity <= 1'b0;
      o_chan_a_validity_flag <= 1'b0;
      o_chan_b_validity_flag <= 1'b0;
      flags_prev <= 4'h2;
      o_trigger <= 1'b0;
    end else begin
      // long over short times 16 beyond threshold
      if (i_pre_valid)
        flag_qual <= long_scaled > short_scaled;
      flag_lock <= !lock_sync;
      // violation held one interval, new error beats clear
      if (i_coding_err)
        flag_coding <= 1'b1;
      else if (tick)
        flag_coding <= 1'b0;
      // even parity over slots 4 to 31
      if (i_sub_valid && (^i_sub_bits[31:4]))
        flag_parity <= 1'b1;
      else if (tick)
        flag_parity <= 1'b0;
      if (i_sub_valid && !i_sub_chan)
        o_chan_a_validity_flag <= i_sub_bits[28];
      if (i_sub_valid && i_sub_chan)
        o_chan_b_validity_flag <= i_sub_bits[28];
      flags_prev <= o_err_flags;
      o_trigger <= |(o_err_flags & ~flags_prev & trig_mask);
    end
  end

endmodule // audio_input_word_monitor
`default_nettype wire

// *** testbench/audio_mon_chk.sv ***
// Purpose: port checks of the audio input word monitor
// Assumes: quality threshold stays at its reset value
// Notes: bound from the bench top
`timescale 1ns/1ns
`default_nettype none
module audio_mon_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sub_valid,
  input wire logic i_sub_chan,
  input wire logic [31:0] i_sub_bits,
  input wire logic i_coding_err,
  input wire logic i_pre_valid,
  input wire logic [7:0] i_pre_amp_long,
  input wire logic [7:0] i_pre_amp_short,
  input wire logic i_pll_locked,
  input wire logic [23:0] o_sample,
  input wire logic o_sample_valid,
  input wire logic o_sample_chan,
  input wire logic [2:0] o_deemph_sel,
  input wire logic [3:0] o_err_flags,
  input wire logic o_chan_a_validity_flag,
  input wire logic o_chan_b_validity_flag,
  input wire logic o_trigger
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------
  // properties
  // ------------------------------------
  a_sample_late:
    assert property (i_sub_valid |=> o_sample_valid && o_sample_chan == $past(i_sub_chan))
      else $error("sample strobe missing");
  a_sample_held:
    assert property (!i_sub_valid |=> $stable(o_sample)) else $error("sample moved");
  a_valid_chan_a:
    assert property (i_sub_valid && !i_sub_chan |=> o_chan_a_validity_flag ==
      $past(i_sub_bits[28])) else $error("channel a validity wrong");
  a_valid_chan_b:
    assert property (i_sub_valid && i_sub_chan |=> o_chan_b_validity_flag ==
      $past(i_sub_bits[28])) else $error("channel b validity wrong");
  a_parity_flag:
    assert property (i_sub_valid && (^i_sub_bits[31:4]) |=> o_err_flags[3])
      else $error("parity flag missing");
  a_coding_flag:
    assert property (i_coding_err |=> o_err_flags[2]) else $error("coding flag missing");
  a_lock_flag:
    assert property (!i_pll_locked [*5] |-> o_err_flags[1]) else $error("lock flag missing");
  a_quality_flag:
    assert property (i_pre_valid |=> o_err_flags[0] == ({4'h0, $past(i_pre_amp_long), 4'h0} >
      $past(i_pre_amp_short) * 16'h0030)) else $error("quality flag wrong");
  a_deemph_range:
    assert property (o_deemph_sel <= 3'h4) else $error("de-emphasis code out of range");
  c_parity: cover property (o_err_flags[3]);
  c_trigger: cover property (o_trigger);
  c_invalid: cover property (i_sub_valid && i_sub_bits[28]);
endmodule // audio_mon_chk
`default_nettype wire

// *** testbench/audio_tx_model.sv ***
// Purpose: transmitter under test feeding decoded subframes
// Assumes: bench sets the control variables hierarchically
// Notes: streams without gaps so every interval sees the whole table
`timescale 1ns/1ns
`default_nettype none
module audio_tx_model (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_sub_valid,
  output logic o_sub_chan,
  output logic [31:0] o_sub_bits,
  output logic [4:0] o_in_len,
  output logic o_coding_err,
  output logic o_pre_valid,
  output logic [7:0] o_amp_long,
  output logic [7:0] o_amp_short,
  output logic o_locked
);
  logic [23:0] words [4];
  logic v_a, bad_par, bad_code, lock, va;
  logic [4:0] in_len;
  logic [7:0] amp_l;
  logic [2:0] k;
  logic [23:0] w;
  assign w = words[k[2:1]];
  assign va = v_a ^ k[0];
  assign o_in_len = in_len;
  assign o_amp_long = amp_l;
  assign o_amp_short = 8'h0A;
  assign o_locked = lock;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      k <= 3'h0;
      o_sub_valid <= 1'b0;
      o_sub_chan <= 1'b0;
      o_sub_bits <= 32'h0;
      o_pre_valid <= 1'b0;
      o_coding_err <= 1'b0;
    end else begin
      k <= k + 3'h1;
      o_sub_valid <= 1'b1;
      o_pre_valid <= 1'b1;
      o_sub_chan <= k[0];
      o_coding_err <= bad_code;
      o_sub_bits <= {^{va, w} ^ bad_par, 2'h0, va, w, 4'h0};
    end
  end
endmodule // audio_tx_model
`default_nettype wire

// *** testbench/tb_audio_input_word_monitor.sv ***
// Purpose: self-checking bench of the audio input word monitor
// Assumes: interval shortened to 64 cycles
// Notes: quality threshold stays at reset
`timescale 1ns/1ns
`default_nettype none
`include "audio_mon_defs.vh"
module tb_audio_input_word_monitor;
  logic i_clk, i_rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [17:0] txr, msr, str;
  wire awready, wready, bvalid, arready, rvalid, sv, sch, cerr, pv, lk, trig, va, vb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, sbits;
  wire [23:0] sample;
  wire [2:0] dsel;
  wire [17:0] scale;
  wire [4:0] txlen, inlen;
  wire [3:0] flags;
  wire [7:0] al, as;
  int fail_count, comparisons;
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  audio_tx_model u_tx (.i_clk(i_clk), .i_rst(i_rst), .o_sub_valid(sv), .o_sub_chan(sch),
    .o_sub_bits(sbits), .o_in_len(inlen), .o_coding_err(cerr), .o_pre_valid(pv),
    .o_amp_long(al), .o_amp_short(as), .o_locked(lk));
  audio_input_word_monitor #(.INTERVAL_CYCLES(64)) i_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_sub_valid(sv), .i_sub_chan(sch), .i_sub_bits(sbits), .i_in_len(inlen),
    .i_coding_err(cerr), .i_pre_valid(pv), .i_pre_amp_long(al), .i_pre_amp_short(as),
    .i_pll_locked(lk), .i_tx_rate(txr), .i_meas_rate(msr), .i_status_rate(str),
    .o_sample(sample), .o_sample_valid(), .o_sample_chan(), .o_deemph_sel(dsel),
    .o_scale_rate(scale), .o_tx_word_len(txlen), .o_err_flags(flags),
    .o_chan_a_validity_flag(va), .o_chan_b_validity_flag(vb), .o_trigger(trig));
  // ------------------------------------
  // helpers
  // ------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw = 1'b1, w = 1'b1;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge i_clk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge i_clk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge i_clk);
    while (!arready) @(posedge i_clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge i_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  function automatic logic [31:0] cw(input int ln, law, de, src, pk, vw, tg);
    return ln | (law << 5) | (de << 7) | (src << 10) | (pk << 12) | (vw << 14) | (tg << 15);
  endfunction
  task automatic words4(input logic [23:0] a, b, c, d);
    @(posedge i_clk);
    u_tx.words[0] <= a;
    u_tx.words[1] <= b;
    u_tx.words[2] <= c;
    u_tx.words[3] <= d;
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rc("ctrl", `REG_CTRL, 32'h00000418);
    rc("tx_len", `REG_TX_LEN, 32'h00000018);
    rc("rate_ref", `REG_RATE_REF, 32'h0000BB80);
    rc("qual_thr", `REG_QUAL_THR, 32'h00000030);
    rd(8'h28, d, r);
    chk("unmapped", r, 32'h2);
    wr(`REG_SCALE, 32'h0, r);
    chk("read_only", r, 32'h2);
    wc(`REG_TX_LEN, 32'h0000000C);
    chk("tx_len_out", txlen, 32'h0C);
    rc("rx_len_kept", `REG_CTRL, 32'h00000418);
  endtask
  task automatic t_len;
    logic [4:0] ln [5] = '{5'h18, 5'h15, 5'h14, 5'h08, 5'h07};
    logic [4:0] il [5] = '{5'h18, 5'h18, 5'h10, 5'h18, 5'h18};
    logic [23:0] ex [5] = '{24'h123457, 24'h123450, 24'h123450, 24'h120000, 24'h120000};
    words4(24'h123457, 24'h123457, 24'h123457, 24'h123457);
    for (int i = 0; i < 5; i++) begin
      wc(`REG_CTRL, cw(ln[i], 0, 0, 1, 0, 0, 0));
      u_tx.in_len <= il[i];
      repeat (4) @(posedge i_clk);
      chk("sample_len", sample, ex[i]);
    end
    rc("len_ignored", `REG_CTRL, cw(8, 0, 0, 1, 0, 0, 0));
  endtask
  task automatic t_law;
    logic [23:0] ex [3] = '{24'h000000, 24'h000800, 24'hD51234};
    logic [23:0] cd [3] = '{24'hFF1234, 24'hD51234, 24'hD51234};
    for (int i = 0; i < 3; i++) begin
      words4(cd[i], cd[i], cd[i], cd[i]);
      wc(`REG_CTRL, cw(8 + 16 * (i / 2), (i + 1) % 3, 0, 1, 0, 0, 0));
      repeat (4) @(posedge i_clk);
      chk("law", sample, ex[i]);
    end
  endtask
  task automatic t_deemph;
    for (int i = 0; i < 6; i++) begin
      wc(`REG_CTRL, cw(24, 0, i, 1, 0, 0, 0));
      @(posedge i_clk);
      chk("deemph", dsel, (i > 4) ? 4 : i);
    end
  endtask
  task automatic t_scale;
    logic [31:0] rv [4] = '{32'h7080, 32'h707F, 32'h34BC0, 32'h34BC1};
    logic [17:0] re [4] = '{18'h07080, 18'h07080, 18'h34BC0, 18'h34BC0};
    logic [17:0] sr [3] = '{18'h0AC44, 18'h0BB7F, 18'h17700};
    for (int i = 0; i < 3; i++) begin
      wc(`REG_CTRL, cw(24, 0, 0, i, 0, 0, 0));
      repeat (2) @(posedge i_clk);
      chk("scale_src", scale, sr[i]);
    end
    wc(`REG_CTRL, cw(24, 0, 0, 3, 0, 0, 0));
    for (int i = 0; i < 4; i++) begin
      wc(`REG_RATE_REF, rv[i]);
      repeat (2) @(posedge i_clk);
      chk("user_rate", scale, re[i]);
    end
  endtask
  task automatic t_peak;
    logic [31:0] ex [4] = '{32'h00000100, 32'hFFFFFD00, 32'h00000300, 32'h00000200};
    words4(24'h000100, 24'hFFFD00, 24'h000050, 24'hFFFFF0);
    for (int m = 0; m < 4; m++) begin
      wc(`REG_CTRL, cw(24, 0, 2, 1, m, 0, 0));
      repeat (200) @(posedge i_clk);
      rc("peak_a", `REG_PEAK_A, ex[m]);
      rc("peak_b", `REG_PEAK_B, ex[m]);
    end
  endtask
  task automatic t_bits;
    words4(24'hA5A5A5, 24'hA5A5A5, 24'hA5A5A5, 24'hA5A5A5);
    wc(`REG_CTRL, cw(24, 0, 0, 1, 0, 0, 0));
    repeat (200) @(posedge i_clk);
    rc("bits_level", `REG_BITS_A, 32'h00A5A5A5);
    words4(24'h000001, 24'h800001, 24'h000001, 24'h800001);
    wc(`REG_CTRL, cw(24, 0, 0, 1, 0, 1, 0));
    repeat (200) @(posedge i_clk);
    rc("bits_active", `REG_BITS_B, 32'h00800000);
  endtask
  task automatic t_flags;
    logic seen = 1'b0;
    u_tx.v_a <= 1'b1;
    wc(`REG_CTRL, cw(24, 0, 0, 1, 0, 0, 8));
    chk("valid_a", {va, vb}, 32'h2);
    u_tx.bad_par <= 1'b1;
    repeat (20) begin
      @(posedge i_clk);
      seen = seen | trig;
    end
    chk("trigger", seen, 32'h1);
    chk("parity", flags[3], 32'h1);
    u_tx.bad_par <= 1'b0;
    u_tx.bad_code <= 1'b1;
    repeat (200) @(posedge i_clk);
    chk("parity_clear", flags[3:2], 32'h1);
    u_tx.bad_code <= 1'b0;
    u_tx.lock <= 1'b0;
    u_tx.amp_l <= 8'hC8;
    repeat (6) @(posedge i_clk);
    chk("lock_quality", {flags[1], flags[0]}, 32'h3);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {i_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = 48'h0;
    {txr, msr, str} = {18'h0AC44, 18'h0BB7F, 18'h17700};
    {u_tx.v_a, u_tx.bad_par, u_tx.bad_code, u_tx.lock} = 4'h1;
    u_tx.in_len = 5'h18;
    u_tx.amp_l = 8'h10;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    t_regs;
    t_len;
    t_law;
    t_deemph;
    t_scale;
    t_peak;
    t_bits;
    t_flags;
    close_out;
  end
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule // tb_audio_input_word_monitor
bind audio_input_word_monitor audio_mon_chk i_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_sub_valid(i_sub_valid), .i_sub_chan(i_sub_chan), .i_sub_bits(i_sub_bits),
  .i_coding_err(i_coding_err), .i_pre_valid(i_pre_valid), .i_pre_amp_long(i_pre_amp_long),
  .i_pre_amp_short(i_pre_amp_short), .i_pll_locked(i_pll_locked), .o_sample(o_sample),
  .o_sample_valid(o_sample_valid), .o_sample_chan(o_sample_chan), .o_deemph_sel(o_deemph_sel),
  .o_err_flags(o_err_flags), .o_chan_a_validity_flag(o_chan_a_validity_flag),
  .o_chan_b_validity_flag(o_chan_b_validity_flag), .o_trigger(o_trigger));
`default_nettype wire
